// [switch_strap_expansion.sv]
// Behaviour
// [RULE1] every network indicator output is driven active high so a one lights its lamp.
// [RULE2] two writable application switch registers sit at 0x5200 (node address) and 0x5201 (other settings).
// [RULE3] the host itself fetches the switch values and writes them into the application switch registers.
// [RULE4] both strap buses are sampled and decoded into the serial settings before any telegram is served.
// [RULE5] the strap buses fix serial settings at startup and later carry configuration switch levels.
// [RULE6] only after the first telegram may outside logic use transmit enable to swap the buses to the switches.
// [RULE7] the live levels of both strap buses read back in the switch status register at 0x0ffd.
// [RULE8] the startup settings are latched once and later bus changes leave them alone.
// [RULE9] transmit enable is driven high while the device transmits.
// [RULE10] the slave address comes from the address straps, legal 1 to 247, else the fault state.
// [RULE11] line strap bits 1:0 pick framing: even, odd, two stop no parity, one stop no parity.
// [RULE12] line strap bits 7:2 pick baud 9600, 19200, 38400, 57600, 115200, 625000; other codes are reserved.
`timescale 1ns/1ps
`default_nettype none
module switch_strap_expansion #(
  parameter int STRAP_W = switch_strap_pkg::STRAP_WIDTH  // strap bus width
) (
  input wire logic sys_clk_in,                       // 10 MHz clock
  input wire logic reset_n_in,                       // async reset, active low
  input wire logic [STRAP_W-1:0] address_strap_bus_in,       // address strap / switch bus
  input wire logic [STRAP_W-1:0] line_settings_strap_bus_in, // line strap / switch bus
  input wire logic [15:0] reg_addr_in,               // decoded telegram register address
  input wire logic reg_wr_in,                        // register write strobe
  input wire logic reg_rd_in,                        // register read strobe
  input wire logic [15:0] reg_wdata_in,              // register write data
  input wire logic telegram_done_in,                 // telegram exchange finished
  input wire logic tx_busy_in,                       // serial transmitter active
  input wire logic [7:0] net_indicator_req_in,       // indicator on requests
  output logic [15:0] reg_rdata_out,                 // register read data
  output logic reg_ack_out,                          // access accepted
  output logic reg_err_out,                          // access refused
  output logic [7:0] slave_address_out,              // active slave address
  output logic [1:0] parity_mode_out,                // active parity
  output logic two_stop_out,                         // active stop bits
  output logic [15:0] bit_cycles_out,                // active clocks per bit
  output logic settings_valid_out,                   // serial settings usable
  output logic fault_state_out,                      // invalid straps
  output logic first_telegram_seen_out,              // buses may now be swapped
  output logic transmit_enable_out,                  // line driver enable
  output logic [15:0] node_address_switch_out,       // node address register
  output logic [15:0] comm_settings_switch_out,      // comm settings register
  output logic net_indicator_one_a_out,              // indicator 1a
  output logic net_indicator_one_b_out,              // indicator 1b
  output logic net_indicator_two_a_out,              // indicator 2a
  output logic net_indicator_two_b_out,              // indicator 2b
  output logic net_indicator_three_a_out,            // indicator 3a
  output logic net_indicator_three_b_out,            // indicator 3b
  output logic net_indicator_four_a_out,             // indicator 4a
  output logic net_indicator_four_b_out              // indicator 4b
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (STRAP_W != 8)
  begin : g_bad_width
    $error("strap width must be 8");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  switch_strap_pkg::boot_state_e state_r, state_nxt;
  logic [7:0] addr_latch_r, addr_latch_nxt;
  logic [7:0] line_latch_r, line_latch_nxt;
  logic [15:0] node_sw_r, node_sw_nxt;
  logic [15:0] comm_sw_r, comm_sw_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic first_seen_r, first_seen_nxt;
  logic tx_en_r, tx_en_nxt;
  logic [7:0] ind_r, ind_nxt;
  logic [1:0] dec_parity;
  logic dec_two_stop;
  logic [15:0] dec_bit_cycles;
  logic dec_valid;
  logic [1:0] parity_r, parity_nxt;
  logic two_stop_r, two_stop_nxt;
  logic [15:0] bit_cyc_r, bit_cyc_nxt;
  logic access;

  // ---------------------------------------------------------------
  // strap decode
  // ---------------------------------------------------------------
  strap_decoder u_decoder (
    .address_strap_in (addr_latch_r),
    .line_strap_in (line_latch_r),
    .parity_mode_out (dec_parity),
    .two_stop_out (dec_two_stop),
    .bit_cycles_out (dec_bit_cycles),
    .valid_out (dec_valid)
  );

  assign access = reg_wr_in || reg_rd_in;

  // startup sequencing and setting latch
  always_comb
  begin
    state_nxt = state_r;
    addr_latch_nxt = addr_latch_r;
    line_latch_nxt = line_latch_r;
    parity_nxt = parity_r;
    two_stop_nxt = two_stop_r;
    bit_cyc_nxt = bit_cyc_r;
    case (state_r)
      switch_strap_pkg::ST_SAMPLE:
      begin
        addr_latch_nxt = address_strap_bus_in; // [RULE4] [RULE5]
        line_latch_nxt = line_settings_strap_bus_in; // [RULE4]
        state_nxt = switch_strap_pkg::ST_CHECK;
      end
      switch_strap_pkg::ST_CHECK:
      begin
        parity_nxt = dec_parity; // [RULE11]
        two_stop_nxt = dec_two_stop;
        bit_cyc_nxt = dec_bit_cycles; // [RULE12]
        state_nxt = dec_valid ? switch_strap_pkg::ST_RUN : switch_strap_pkg::ST_FAULT; // [RULE10]
      end
      switch_strap_pkg::ST_RUN: state_nxt = switch_strap_pkg::ST_RUN; // [RULE8] never resampled
      switch_strap_pkg::ST_FAULT: state_nxt = switch_strap_pkg::ST_FAULT;
      default: state_nxt = switch_strap_pkg::ST_SAMPLE;
    endcase
  end

  // startup registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= switch_strap_pkg::ST_SAMPLE;
      addr_latch_r <= 8'h00;
      line_latch_r <= 8'h00;
      parity_r <= 2'h0;
      two_stop_r <= 1'b0;
      bit_cyc_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      addr_latch_r <= addr_latch_nxt;
      line_latch_r <= line_latch_nxt;
      parity_r <= parity_nxt;
      two_stop_r <= two_stop_nxt;
      bit_cyc_r <= bit_cyc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  // decode reads and writes, served only while running
  always_comb
  begin
    node_sw_nxt = node_sw_r;
    comm_sw_nxt = comm_sw_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (access && (state_r == switch_strap_pkg::ST_RUN)) // [RULE4]
    begin
      case (reg_addr_in)
        switch_strap_pkg::STRAP_SWITCH_STATUS_ADDR:
        begin
          if (reg_wr_in)
            err_nxt = 1'b1;
          else
          begin
            rdata_nxt = {line_settings_strap_bus_in, address_strap_bus_in}; // [RULE7] live levels
            ack_nxt = 1'b1;
          end
        end
        switch_strap_pkg::NODE_ADDRESS_SWITCH_ADDR:
        begin
          if (reg_wr_in)
            node_sw_nxt = reg_wdata_in; // [RULE2] [RULE3]
          rdata_nxt = reg_wr_in ? reg_wdata_in : node_sw_r;
          ack_nxt = 1'b1;
        end
        switch_strap_pkg::COMM_SETTINGS_SWITCH_ADDR:
        begin
          if (reg_wr_in)
            comm_sw_nxt = reg_wdata_in; // [RULE2]
          rdata_nxt = reg_wr_in ? reg_wdata_in : comm_sw_r;
          ack_nxt = 1'b1;
        end
        default: err_nxt = 1'b1;
      endcase
    end
    else if (access)
      err_nxt = 1'b1;
  end

  // register file flops
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      node_sw_r <= switch_strap_pkg::NODE_ADDRESS_SWITCH_RESET;
      comm_sw_r <= switch_strap_pkg::COMM_SETTINGS_SWITCH_RESET;
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      node_sw_r <= node_sw_nxt;
      comm_sw_r <= comm_sw_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // link side outputs
  // ---------------------------------------------------------------
  // first telegram flag, transmit enable, indicators
  always_comb
  begin
    first_seen_nxt = first_seen_r;
    if (telegram_done_in && (state_r == switch_strap_pkg::ST_RUN))
      first_seen_nxt = 1'b1; // [RULE6]
    tx_en_nxt = tx_busy_in && (state_r == switch_strap_pkg::ST_RUN); // [RULE9]
    ind_nxt = net_indicator_req_in; // [RULE1] one means lit
  end

  // link side flops
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      first_seen_r <= 1'b0;
      tx_en_r <= 1'b0;
      ind_r <= 8'h00;
    end
    else
    begin
      first_seen_r <= first_seen_nxt;
      tx_en_r <= tx_en_nxt;
      ind_r <= ind_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  assign reg_rdata_out = rdata_r;
  assign reg_ack_out = ack_r;
  assign reg_err_out = err_r;
  assign slave_address_out = addr_latch_r; // [RULE10] [RULE8]
  assign parity_mode_out = parity_r;
  assign two_stop_out = two_stop_r;
  assign bit_cycles_out = bit_cyc_r;
  assign settings_valid_out = (state_r == switch_strap_pkg::ST_RUN);
  assign fault_state_out = (state_r == switch_strap_pkg::ST_FAULT); // [RULE10]
  assign first_telegram_seen_out = first_seen_r;
  assign transmit_enable_out = tx_en_r;
  assign node_address_switch_out = node_sw_r;
  assign comm_settings_switch_out = comm_sw_r;
  assign net_indicator_one_a_out = ind_r[0];
  assign net_indicator_one_b_out = ind_r[1];
  assign net_indicator_two_a_out = ind_r[2];
  assign net_indicator_two_b_out = ind_r[3];
  assign net_indicator_three_a_out = ind_r[4];
  assign net_indicator_three_b_out = ind_r[5];
  assign net_indicator_four_a_out = ind_r[6];
  assign net_indicator_four_b_out = ind_r[7];

endmodule : switch_strap_expansion
`default_nettype wire

// [switch_strap_pkg.sv]
`default_nettype none
package switch_strap_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] STRAP_SWITCH_STATUS_ADDR = 16'h0ffd;
  localparam logic [15:0] NODE_ADDRESS_SWITCH_ADDR = 16'h5200;
  localparam logic [15:0] COMM_SETTINGS_SWITCH_ADDR = 16'h5201;
  localparam logic [15:0] NODE_ADDRESS_SWITCH_RESET = 16'h0000;
  localparam logic [15:0] COMM_SETTINGS_SWITCH_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // strap fields
  // ---------------------------------------------------------------
  localparam int STRAP_WIDTH = 8;
  localparam int FRAMING_LSB = 0;
  localparam int BAUD_LSB = 2;
  localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ADDR_MAX = 8'hf7;

  // framing codes
  localparam logic [1:0] FRAME_1S_EVEN = 2'h0;
  localparam logic [1:0] FRAME_1S_ODD = 2'h1;
  localparam logic [1:0] FRAME_2S_NONE = 2'h2;
  localparam logic [1:0] FRAME_1S_NONE = 2'h3;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_EVEN = 2'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;

  // baud codes
  localparam logic [5:0] BAUD_CODE_9600 = 6'h03;
  localparam logic [5:0] BAUD_CODE_19200 = 6'h04;
  localparam logic [5:0] BAUD_CODE_38400 = 6'h05;
  localparam logic [5:0] BAUD_CODE_57600 = 6'h06;
  localparam logic [5:0] BAUD_CODE_115200 = 6'h08;
  localparam logic [5:0] BAUD_CODE_625000 = 6'h09;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int BIT_CYC_9600 = CLK_HZ / 9600;
  localparam int BIT_CYC_19200 = CLK_HZ / 19200;
  localparam int BIT_CYC_38400 = CLK_HZ / 38400;
  localparam int BIT_CYC_57600 = CLK_HZ / 57600;
  localparam int BIT_CYC_115200 = CLK_HZ / 115200;
  localparam int BIT_CYC_625000 = CLK_HZ / 625000;

  // ---------------------------------------------------------------
  // startup states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b10,
    ST_FAULT = 2'b11
  } boot_state_e;

endpackage : switch_strap_pkg
`default_nettype wire

// [strap_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module strap_decoder (
  input wire logic [7:0] address_strap_in,  // latched address straps
  input wire logic [7:0] line_strap_in,     // latched line-settings straps
  output logic [1:0] parity_mode_out,       // none / even / odd
  output logic two_stop_out,                // two stop bits
  output logic [15:0] bit_cycles_out,       // clocks per bit
  output logic valid_out                    // straps are legal
);

  logic [1:0] framing;
  logic [5:0] baud_code;
  logic baud_ok;
  logic addr_ok;

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  assign framing = line_strap_in[switch_strap_pkg::FRAMING_LSB +: 2];
  assign baud_code = line_strap_in[switch_strap_pkg::BAUD_LSB +: 6];

  // address range check
  assign addr_ok = (address_strap_in >= switch_strap_pkg::SLAVE_ADDR_MIN) &&
                   (address_strap_in <= switch_strap_pkg::SLAVE_ADDR_MAX); // [RULE10]

  // framing decode
  always_comb
  begin
    parity_mode_out = switch_strap_pkg::PARITY_NONE;
    two_stop_out = 1'b0;
    case (framing) // [RULE11]
      switch_strap_pkg::FRAME_1S_EVEN: parity_mode_out = switch_strap_pkg::PARITY_EVEN;
      switch_strap_pkg::FRAME_1S_ODD: parity_mode_out = switch_strap_pkg::PARITY_ODD;
      switch_strap_pkg::FRAME_2S_NONE: two_stop_out = 1'b1;
      default: parity_mode_out = switch_strap_pkg::PARITY_NONE;
    endcase
  end

  // baud decode, reserved codes refused
  always_comb
  begin
    baud_ok = 1'b1;
    bit_cycles_out = 16'h0000;
    case (baud_code) // [RULE12]
      switch_strap_pkg::BAUD_CODE_9600: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_9600);
      switch_strap_pkg::BAUD_CODE_19200: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_19200);
      switch_strap_pkg::BAUD_CODE_38400: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_38400);
      switch_strap_pkg::BAUD_CODE_57600: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_57600);
      switch_strap_pkg::BAUD_CODE_115200: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_115200);
      switch_strap_pkg::BAUD_CODE_625000: bit_cycles_out = 16'(switch_strap_pkg::BIT_CYC_625000);
      default: baud_ok = 1'b0;
    endcase
  end

  assign valid_out = addr_ok && baud_ok; // [RULE10]

endmodule : strap_decoder
`default_nettype wire

// [switch_strap_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module switch_strap_sva #(
  parameter int STRAP_W = 8 // strap bus width
) (
  input wire logic sys_clk_in, // clock
  input wire logic reset_n_in, // reset
  input wire logic [STRAP_W-1:0] address_strap_bus_in, // address bus
  input wire logic [STRAP_W-1:0] line_settings_strap_bus_in, // line bus
  input wire logic [15:0] reg_addr_in, // address
  input wire logic reg_wr_in, // write
  input wire logic reg_rd_in, // read
  input wire logic [15:0] reg_wdata_in, // write data
  input wire logic telegram_done_in, // telegram end
  input wire logic tx_busy_in, // sending
  input wire logic [15:0] reg_rdata_out, // read data
  input wire logic reg_ack_out, // accepted
  input wire logic reg_err_out, // refused
  input wire logic [7:0] slave_address_out, // address
  input wire logic [15:0] bit_cycles_out, // bit time
  input wire logic settings_valid_out, // run
  input wire logic fault_state_out, // fault
  input wire logic first_telegram_seen_out, // seen
  input wire logic transmit_enable_out, // driver enable
  input wire logic [15:0] node_address_switch_out // node register
);
  // ---------------------------------------------------------------
  // startup and register checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // startup steps
  sequence s_release;
    $rose(reset_n_in);
  endsequence
  sequence s_decoded;
    ##2 (settings_valid_out != fault_state_out);
  endsequence

  AST_BOOT: assert property (s_release |-> s_decoded)
    else $error("startup decode missing");
  AST_FAULT: assert property (s_release |-> ##2 (fault_state_out == (slave_address_out < 8'h01
    || slave_address_out > 8'hf7 || bit_cycles_out == 16'h0000)))
    else $error("fault state wrong");
  AST_LATCH: assert property (settings_valid_out |=> $stable(slave_address_out) && $stable(bit_cycles_out))
    else $error("settings changed");
  AST_TXEN: assert property (settings_valid_out |=> transmit_enable_out == $past(tx_busy_in))
    else $error("transmit enable wrong");
  AST_TX_IDLE: assert property (!settings_valid_out |-> !transmit_enable_out)
    else $error("transmit enable outside run");
  AST_ANSWER: assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out != reg_err_out)
    else $error("access not answered");
  AST_STATUS: assert property (settings_valid_out && reg_rd_in && reg_addr_in == 16'h0ffd |=> reg_ack_out
    && reg_rdata_out == {$past(line_settings_strap_bus_in), $past(address_strap_bus_in)})
    else $error("status read wrong");
  AST_RO: assert property (reg_wr_in && reg_addr_in == 16'h0ffd |=> reg_err_out)
    else $error("status write accepted");
  AST_NODE_WR: assert property (settings_valid_out && reg_wr_in && reg_addr_in == 16'h5200
    |=> node_address_switch_out == $past(reg_wdata_in))
    else $error("node write lost");
  AST_SEEN: assert property (settings_valid_out && telegram_done_in |=> first_telegram_seen_out)
    else $error("telegram flag not set");
endmodule : switch_strap_sva
`default_nettype wire

// [switch_board.sv]
`timescale 1ns/1ps
`default_nettype none
module switch_board (
  input wire logic transmit_enable_in, // driver enable
  input wire logic swap_ok_in, // first telegram done
  input wire logic [7:0] strap_a_in, // address straps
  input wire logic [7:0] strap_l_in, // line straps
  input wire logic [7:0] sw_a_in, // address switches
  input wire logic [7:0] sw_l_in, // line switches
  output logic [7:0] addr_bus_out, // address bus
  output logic [7:0] line_bus_out // line bus
);
  // enable swaps buses to switches, never before first telegram
  assign addr_bus_out = (swap_ok_in && transmit_enable_in) ? sw_a_in : strap_a_in;
  assign line_bus_out = (swap_ok_in && transmit_enable_in) ? sw_l_in : strap_l_in;
endmodule : switch_board
`default_nettype wire

// [switch_strap_expansion_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module switch_strap_expansion_bench;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] address_strap_bus_in, line_settings_strap_bus_in, slave_address_out, req;
  wire logic [7:0] ind; // indicator pins, one port per bit
  logic [15:0] reg_addr_in = 16'h0000, reg_wdata_in = 16'h0000, rd;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, telegram_done_in = 1'b0, tx_busy_in = 1'b1;
  logic [7:0] net_indicator_req_in = 8'h00, strap_a = 8'h01, strap_l = 8'h0c, sw_a = 8'h00, sw_l = 8'h00;
  logic [15:0] reg_rdata_out, bit_cycles_out, node_address_switch_out, comm_settings_switch_out;
  logic reg_ack_out, reg_err_out, two_stop_out, settings_valid_out, fault_state_out, tx;
  logic first_telegram_seen_out, transmit_enable_out, swap_ok = 1'b0;
  logic [1:0] parity_mode_out;
  int error_cnt = 0;
  int tests_run = 0;

  // ---------------------------------------------------------------
  // design, far side and clock
  // ---------------------------------------------------------------
  switch_strap_expansion u_switch_strap_expansion (.sys_clk_in, .reset_n_in, .address_strap_bus_in,
    .line_settings_strap_bus_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .telegram_done_in,
    .tx_busy_in, .net_indicator_req_in, .reg_rdata_out, .reg_ack_out, .reg_err_out, .slave_address_out,
    .parity_mode_out, .two_stop_out, .bit_cycles_out, .settings_valid_out, .fault_state_out,
    .first_telegram_seen_out, .transmit_enable_out, .node_address_switch_out, .comm_settings_switch_out,
    .net_indicator_one_a_out(ind[0]), .net_indicator_one_b_out(ind[1]), .net_indicator_two_a_out(ind[2]),
    .net_indicator_two_b_out(ind[3]), .net_indicator_three_a_out(ind[4]), .net_indicator_three_b_out(ind[5]),
    .net_indicator_four_a_out(ind[6]), .net_indicator_four_b_out(ind[7]));
  switch_board u_switch_board (.transmit_enable_in(transmit_enable_out), .swap_ok_in(swap_ok),
    .strap_a_in(strap_a), .strap_l_in(strap_l), .sw_a_in(sw_a), .sw_l_in(sw_l),
    .addr_bus_out(address_strap_bus_in), .line_bus_out(line_settings_strap_bus_in));
  // free running clock
  initial
  begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] exp_cyc(input logic [5:0] c);
    case (c)
      6'h03: return 16'h0411;
      6'h04: return 16'h0208;
      6'h05: return 16'h0104;
      6'h06: return 16'h00ad;
      6'h08: return 16'h0056;
      6'h09: return 16'h0010;
      default: return 16'h0000;
    endcase
  endfunction : exp_cyc
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : check
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // one access, answer seen the cycle after the taking edge
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic ok);
    @(posedge sys_clk_in);
    #1;
    reg_wr_in = wr;
    reg_rd_in = !wr;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge sys_clk_in);
    #1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    check({15'h0000, reg_ack_out}, {15'h0000, ok});
    check({15'h0000, reg_err_out}, {15'h0000, !ok});
    rd = reg_rdata_out;
  endtask : access
  // reset with given straps, early access refused, then decode checked
  task automatic boot(input logic [7:0] a, input logic [7:0] l);
    logic bad;
    bad = (a < 8'h01) || (a > 8'hf7) || (exp_cyc(l[7:2]) == 16'h0000);
    swap_ok = 1'b0;
    strap_a = a;
    strap_l = l;
    reset_n_in = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    #1;
    reset_n_in = 1'b1;
    reg_rd_in = 1'b1;
    telegram_done_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    reg_rd_in = 1'b0;
    telegram_done_in = 1'b0;
    check({15'h0000, reg_err_out}, 16'h0001);
    @(posedge sys_clk_in);
    #1;
    check({15'h0000, fault_state_out}, {15'h0000, bad});
    check({15'h0000, settings_valid_out}, {15'h0000, !bad});
    if (!bad)
    begin
      check({8'h00, slave_address_out}, {8'h00, a});
      check({14'h0000, parity_mode_out}, (l[1:0] == 2'h0) ? 16'h0001 : (l[1:0] == 2'h1) ? 16'h0002 : 16'h0000);
      check({15'h0000, two_stop_out}, {15'h0000, l[1:0] == 2'h2});
      check(bit_cycles_out, exp_cyc(l[7:2]));
    end
    check({15'h0000, first_telegram_seen_out}, 16'h0000);
    // one more edge so the startup assertions complete before the next reset
    @(posedge sys_clk_in);
    #1;
  endtask : boot

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2bf154d8));
    for (int f = 0; f < 4; f++)
      boot(8'h01, {6'h04, 2'(f)});
    for (int b = 0; b < 11; b++)
      boot(8'hf7, {6'(b), 2'h3});
    boot(8'h00, 8'h0c);
    boot(8'hf8, 8'h0c);
    boot(8'($urandom_range(1, 247)), {6'h09, 2'($urandom)});
    access(1'b0, 16'h0ffd, 16'h0000, 1'b1);
    check(rd, {strap_l, strap_a});
    @(posedge sys_clk_in);
    #1;
    telegram_done_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    telegram_done_in = 1'b0;
    check({15'h0000, first_telegram_seen_out}, 16'h0001);
    swap_ok = 1'b1;
    sw_a = 8'($urandom);
    sw_l = 8'($urandom);
    tx_busy_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    check({15'h0000, transmit_enable_out}, 16'h0001);
    access(1'b0, 16'h0ffd, 16'h0000, 1'b1);
    check(rd, {sw_l, sw_a});
    check({8'h00, slave_address_out}, {8'h00, strap_a});
    check(bit_cycles_out, 16'h0010);
    tx_busy_in = 1'b0;
    // host copies switch levels into the application registers
    access(1'b1, 16'h5200, {8'h00, sw_a}, 1'b1);
    check(node_address_switch_out, {8'h00, sw_a});
    access(1'b1, 16'h5201, {8'h00, sw_l}, 1'b1);
    access(1'b0, 16'h5200, 16'h0000, 1'b1);
    check(rd, {8'h00, sw_a});
    access(1'b0, 16'h5201, 16'h0000, 1'b1);
    check(rd, {8'h00, sw_l});
    check(comm_settings_switch_out, {8'h00, sw_l});
    access(1'b1, 16'h0ffd, 16'h1234, 1'b0);
    access(1'b0, 16'h5202, 16'h0000, 1'b0);
    // random indicator and transmitter traffic
    for (int i = 0; i < 40; i++)
    begin
      req = 8'($urandom);
      tx = 1'($urandom);
      net_indicator_req_in = req;
      tx_busy_in = tx;
      @(posedge sys_clk_in);
      #1;
      check({8'h00, ind}, {8'h00, req});
      check({15'h0000, transmit_enable_out}, {15'h0000, tx});
    end
    give_verdict();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    give_verdict();
  end
endmodule : switch_strap_expansion_bench
bind switch_strap_expansion switch_strap_sva #(.STRAP_W(STRAP_W)) u_switch_strap_sva (.sys_clk_in, .reset_n_in,
  .address_strap_bus_in, .line_settings_strap_bus_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
  .telegram_done_in, .tx_busy_in, .reg_rdata_out, .reg_ack_out, .reg_err_out, .slave_address_out, .bit_cycles_out,
  .settings_valid_out, .fault_state_out, .first_telegram_seen_out, .transmit_enable_out, .node_address_switch_out);
`default_nettype wire
